// >>> adc_seq_int_status_clear_test.sv
`timescale 1ns/10ps
module adc_seq_int_status_clear_test;
   import asic_pkg::*;
   logic        ref_clk = 0, nrst = 0, rd = 0, wr = 0, irq, wq;
   logic [3:0]  adr = 0, ev = 0, done, raw = 0, msk = 0;
   logic [31:0] wd = 0, q, got;
   int          fails = 0, total_checks = 0;
   always #10 ref_clk = ~ref_clk;
   asic_seq_source i_src (.ref_clk(ref_clk), .evtReq(ev), .seqDone(done));
   asic_int_status i_dut (.ref_clk(ref_clk), .nrst(nrst), .avsAddress(adr), .avsRead(rd),
      .avsWrite(wr), .avsWritedata(wd), .avsReaddata(q), .avsWaitrequest(wq),
      .seqDone(done), .seqIrq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // The event request rides with the bus request, so its pulse lands on the commit edge.
   task automatic bus(logic w, logic [3:0] a, logic [31:0] d, logic [3:0] e);
      int  n;
      @(posedge ref_clk);
      rd <= !w; wr <= w; adr <= a; wd <= d; ev <= e;
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         ev <= 0;
         if (!wq) begin
            got = q;
            break;
         end
      end
      rd <= 0; wr <= 0;
      if (n == 20) begin
         fails++;
         report_and_stop();
      end
      raw |= e;
      if (w && a == ADDR_INT_ALLOW) msk = d[3:0];
      if (w && a == ADDR_STATUS_CLEAR) raw = (raw & ~d[3:0]) | e;
   endtask
   task automatic look();
      bus(0, ADDR_RAW_FLAGS, 0, 0);
      chk("raw", got, {28'h0, raw});
      bus(0, ADDR_INT_ALLOW, 0, 0);
      chk("mask", got, {28'h0, msk});
      bus(0, ADDR_STATUS_CLEAR, 0, 0);
      chk("status", got, {RESERVED_READ, raw & msk});
      chk("irq", {31'h0, irq}, {31'h0, |(raw & msk)});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h84915f1e));
      repeat (2) @(posedge ref_clk);
      nrst <= 1;
      repeat (3) @(posedge ref_clk);
      look();
      bus(0, 4'h0, 0, 0);
      chk("unmapped", got, 32'h0);
      // Random masks cover clears of raw flags whose status is masked off.
      for (int i = 0; i < 40; i++) begin
         bus(1, ADDR_INT_ALLOW, $urandom, 0);
         bus(1, 4'h0, $urandom, 4'($urandom));
         look();
         bus(1, ADDR_STATUS_CLEAR, $urandom, 4'($urandom));
         look();
      end
      report_and_stop();
   end
endmodule

// >>> asic_int_status.sv
`timescale 1ns/10ps
// Operation
// - Four status bits, bits 3:0, reset zero.
// - Status is raw AND mask; level interrupt.
// - Writing one clears; zero leaves unchanged.
// - Clearing status also clears raw flag.
// - Bits 31:4 reserved, read as zero.
// - Raw flag set on completed enabled sample.
// - Clear raw flag even when masked off.
module asic_int_status
   import asic_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic [3:0]  avsAddress,
   input  wire logic        avsRead,
   input  wire logic        avsWrite,
   input  wire logic [31:0] avsWritedata,
   output logic [31:0]      avsReaddata,
   output logic             avsWaitrequest,
   input  wire logic [3:0]  seqDone,
   output logic             seqIrq
);

   ////////////////////////////////////////////////////////////////////////////
   logic      rstSync1;
   logic      rstSync2;
   asic_req_s req;
   logic [3:0] rawFlagsReg;
   logic [3:0] rawFlagsNext;
   logic [3:0] intAllowNext;
   logic [3:0] intAllowReg;
   logic [3:0] maskedStatus;
   logic       accessCommit;
   logic [3:0] clearMask;
   logic [31:0] readNext;

   assign req = '{address: avsAddress, read: avsRead, write: avsWrite,
                  writedata: avsWritedata};

   // The reset is released through two flops so all logic leaves reset together.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rstSync1 <= 1'b0;
         rstSync2 <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstSync2 <= rstSync1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Waitrequest idles high and drops for one cycle after a request is seen.
   // Every access therefore takes exactly one wait state, and the output comes
   // straight from a flop at the cost of holding an idle bus in the wait state.
   always_ff @(posedge ref_clk or negedge rstSync2) begin
      if (!rstSync2) begin
         avsWaitrequest <= WAIT_RESET;
      end else begin
         avsWaitrequest <= !((req.read || req.write) && avsWaitrequest);
      end
   end

   // A request is committed only at the edge where the master sees waitrequest low.
   assign accessCommit = (req.read || req.write) && !avsWaitrequest;

   // The write commits on the same edge the master sees waitrequest low.
   always_comb begin
      clearMask = 4'h0;
      if (req.write && accessCommit && req.address == ADDR_STATUS_CLEAR) begin
         clearMask = req.writedata[3:0];
      end
   end

   assign maskedStatus = rawFlagsReg & intAllowReg;

   // Set is applied after clear so a completing sample is never lost.
   always_comb begin
      rawFlagsNext = (rawFlagsReg & ~clearMask)
                     | seqDone;
   end

   always_comb begin
      intAllowNext = intAllowReg;
      if (req.write && accessCommit && req.address == ADDR_INT_ALLOW) begin
         intAllowNext = req.writedata[3:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rstSync2) begin
      if (!rstSync2) begin
         rawFlagsReg <= SEQ_FLAGS_RESET;
      end else begin
         rawFlagsReg <= rawFlagsNext;
      end
   end

   always_ff @(posedge ref_clk or negedge rstSync2) begin
      if (!rstSync2) begin
         intAllowReg <= SEQ_FLAGS_RESET;
      end else begin
         intAllowReg <= intAllowNext;
      end
   end

   // The interrupt is built from the next-state flags and mask, so it matches the
   // status bits in the very same cycle; a lagging copy could show a cleared source
   // as still pending to a handler that returns quickly.
   always_ff @(posedge ref_clk or negedge rstSync2) begin
      if (!rstSync2) begin
         seqIrq <= 1'b0;
      end else begin
         seqIrq <= |(rawFlagsNext & intAllowNext);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      readNext = 32'h00000000;
      if (req.address == ADDR_RAW_FLAGS) begin
         readNext = {RESERVED_READ, rawFlagsReg};
      end else if (req.address == ADDR_INT_ALLOW) begin
         readNext = {RESERVED_READ, intAllowReg};
      end else if (req.address == ADDR_STATUS_CLEAR) begin
         readNext = {RESERVED_READ, maskedStatus};
      end
   end

   always_ff @(posedge ref_clk or negedge rstSync2) begin
      if (!rstSync2) begin
         avsReaddata <= READ_RESET;
      end else if (req.read && avsWaitrequest) begin
         avsReaddata <= readNext;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake, read path and mask write.
   status_read_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (req.read && accessCommit && req.address == ADDR_STATUS_CLEAR && $stable(rawFlagsReg)
       && $stable(intAllowReg)) |-> avsReaddata == {28'h0, rawFlagsReg & intAllowReg})
      else $error("status read differs from raw and mask");

   reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (req.read && accessCommit) |-> avsReaddata[31:4] == 28'h0)
      else $error("reserved read bits not zero");

   one_wait_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      ((avsRead || avsWrite) && avsWaitrequest) |=> !avsWaitrequest)
      else $error("access did not end after one wait state");

   wait_idle_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      !(avsRead || avsWrite) |=> avsWaitrequest)
      else $error("waitrequest low without a request");

   unmapped_read_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (avsRead && avsWaitrequest && avsAddress == 4'h0) |=> avsReaddata == 32'h0)
      else $error("unmapped read not zero");

   mask_write_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (avsWrite && !avsWaitrequest && avsAddress == ADDR_INT_ALLOW)
      |=> intAllowReg == $past(avsWritedata[3:0]))
      else $error("mask write did not land");

   // Flag set and clear.
   clear_one_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (clearMask[0] && !seqDone[0]) |=> !rawFlagsReg[0])
      else $error("write one did not clear flag");

   clear_top_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (clearMask[3] && !seqDone[3]) |=> !rawFlagsReg[3])
      else $error("write one did not clear top flag");

   keep_zero_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (req.write && accessCommit && !req.writedata[1] && rawFlagsReg[1]) |=> rawFlagsReg[1])
      else $error("write zero changed flag");

   flag_holds_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (rawFlagsReg[0] && !clearMask[0]) |=> rawFlagsReg[0])
      else $error("flag dropped without a clear");

   event_wins_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (seqDone[2] && clearMask[2]) |=> rawFlagsReg[2])
      else $error("event lost against clear");

   event_sets_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      seqDone[3] |=> rawFlagsReg[3])
      else $error("completion did not set flag");

   raw_readonly_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (req.write && accessCommit && req.address == ADDR_RAW_FLAGS && seqDone == 4'h0)
      |=> rawFlagsReg == $past(rawFlagsReg))
      else $error("write changed raw flags");

   masked_clear_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (clearMask[1] && !intAllowReg[1] && !seqDone[1]) |=> !rawFlagsReg[1])
      else $error("masked flag not cleared");

   // Interrupt output and flag reset value.
   irq_high_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (|maskedStatus) |-> seqIrq)
      else $error("interrupt low with status set");

   irq_level_a: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      ##1 seqIrq == |maskedStatus)
      else $error("interrupt does not follow status");
   reset_zero_a: assert property (@(posedge ref_clk)
      $rose(rstSync2) |-> rawFlagsReg == 4'h0)
      else $error("flags not zero after reset");

endmodule

// >>> asic_pkg.sv
package asic_pkg;

   localparam int          SEQ_COUNT         = 4;
   localparam logic [3:0]  ADDR_RAW_FLAGS    = 4'h4;
   localparam logic [3:0]  ADDR_INT_ALLOW    = 4'h8;
   localparam logic [3:0]  ADDR_STATUS_CLEAR = 4'hc;
   localparam logic [3:0]  SEQ_FLAGS_RESET   = 4'h0;
   localparam logic [27:0] RESERVED_READ     = 28'h0000000;
   localparam logic [31:0] READ_RESET        = 32'h00000000;
   localparam logic        WAIT_RESET        = 1'b1;

   typedef struct packed {
      logic [3:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } asic_req_s;

endpackage

// >>> asic_seq_source.sv
`timescale 1ns/10ps
module asic_seq_source (
   input  wire logic       ref_clk,
   input  wire logic [3:0] evtReq,
   output logic      [3:0] seqDone
);
   // Each request is copied one cycle later as the completion pulse of an enabled sample, as wide as the request.
   always_ff @(posedge ref_clk) seqDone <= evtReq;
endmodule
